// File: hdl/gxp_pkg.sv
`default_nettype none

package gxp_pkg;

    // bus and pin geometry
    localparam int unsigned GXP_ADDR_W      = 7;
    localparam int unsigned GXP_DATA_W      = 8;
    localparam int unsigned GXP_SYNC_STAGES = 2;

    // default slave address, changeable by parameter
    localparam logic [6:0]  GXP_DEV_ADDR    = 7'h20;

    // reset values
    localparam logic [7:0]  GXP_GPIO_RST    = 8'h00;
    localparam logic [2:0]  GXP_CNT_RST     = 3'h0;
    localparam logic [7:0]  GXP_SHIFT_RST   = 8'h00;

    // bit counter values inside a byte
    localparam logic [2:0]  GXP_FIRST_BIT   = 3'h0;
    localparam logic [2:0]  GXP_SECOND_BIT  = 3'h1;
    localparam logic [2:0]  GXP_LAST_BIT    = 3'h7;
    localparam logic [2:0]  GXP_CNT_STEP    = 3'h1;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wr_data,
        st_wr_ack,
        st_rd_data,
        st_rd_ack
    } gxp_state_t;

    // state clocked by the rising edge of the bus clock
    typedef struct packed {
        gxp_state_t  state;
        logic [2:0]  cnt;
        logic [7:0]  rx;
        logic [7:0]  tx;
        logic        rw;
        logic [7:0]  wr_data;
        logic        wr_tog;
        logic        start_ack;
    } gxp_link_t;

    // state clocked by the system clock
    typedef struct packed {
        logic        wr_seen;
        logic [1:0]  frame_seen;
        logic        busy;
        logic [7:0]  gpio_out;
        logic        scl_o;
        logic        scl_oe;
        logic        sda_o;
    } gxp_sys_t;

endpackage

`default_nettype wire

// File: hdl/gxp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module gxp_sync #(
    parameter int unsigned WIDTH  = 1,
    parameter int unsigned STAGES = gxp_pkg::GXP_SYNC_STAGES
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [STAGES-1:0][WIDTH-1:0] chain;
    logic [STAGES-1:0][WIDTH-1:0] next_chain;

    if (STAGES < 2) begin : g_check
        $error("gxp_sync needs at least two stages");
    end

    // first stage only feeds the second
    always_comb
    begin
        next_chain = {chain[STAGES-2:0], d};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            chain <= '0;
        else
            chain <= next_chain;
    end

    assign q = chain[STAGES-1];

endmodule // gxp_sync

`default_nettype wire

// File: hdl/gxp_i2c_gpio.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R01) slave only, answers one fixed 7-bit address set at build time
// (R02) master opens with start, 7 address bits, then a direction bit
// (R03) matching address is acknowledged, then data moves in chosen direction
// (R04) every data byte is followed by one acknowledge slot
// (R05) bytes repeat within a transaction until the master stops it
// (R06) exactly eight input pins and eight output pins
// (R07) all outputs update together, all inputs are captured together
// (R08) write: each received byte goes to outputs until stop or restart
// (R09) read: inputs sampled at the acknowledge bit, then shifted out
// (R10) read bytes repeat until stop or repeated start; the code ends the read at the master's not-acknowledge
// (R11) clock and data pins only pull low or release, never drive high
// (R12) foreign address: no acknowledge, ignore rest until next start
// (R13) outputs hold last written value, change only on completed byte
module gxp_i2c_gpio #(
    parameter logic [6:0] DEV_ADDR = gxp_pkg::GXP_DEV_ADDR
) (
    // system clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // bus clock pin, also the link clock
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    // bus data pin
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // general purpose pins
    input  wire logic [7:0] gpio_in,
    output logic      [7:0] gpio_out,
    // transaction in progress
    output logic            link_busy
);

    gxp_pkg::gxp_link_t link;
    gxp_pkg::gxp_link_t next_link;
    gxp_pkg::gxp_sys_t  sys;
    gxp_pkg::gxp_sys_t  next_sys;

    logic       start_tog;
    logic       stop_tog;
    logic       sda_drive;
    logic       next_sda_drive;
    logic       start_seen;
    logic       addr_hit;
    logic [7:0] gpio_s;
    logic       wr_tog_s;
    logic [1:0] frame_s;
    logic       wr_pulse;

    if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_check
        $error("slave address lies in a reserved range");
    end

    // start and stop markers, clocked by the data line itself
    always_ff @(negedge sda_i or negedge rst_b)
    begin
        if (!rst_b)
            start_tog <= 1'b0;
        else if (scl_i)
            start_tog <= ~start_tog;
    end

    always_ff @(posedge sda_i or negedge rst_b)
    begin
        if (!rst_b)
            stop_tog <= 1'b0;
        else if (scl_i)
            stop_tog <= ~stop_tog;
    end

    // input pins cross into the link domain
    gxp_sync #(
        .WIDTH  (gxp_pkg::GXP_DATA_W),
        .STAGES (gxp_pkg::GXP_SYNC_STAGES)
    ) u_gpio_sync (
        .clk   (scl_i),
        .rst_b (rst_b),
        .d     (gpio_in),
        .q     (gpio_s)
    );

    // the start marker settles half a bus clock before the next rising
    // edge, so the link domain may compare it directly
    assign start_seen = (start_tog != link.start_ack);
    assign addr_hit   = (link.rx[6:0] == DEV_ADDR);

    always_comb
    begin
        next_link = link;
        if (start_seen)
        begin
            // a start or repeated start always wins
            next_link.start_ack = start_tog;
            next_link.state     = gxp_pkg::st_addr;
            next_link.rx        = {7'h00, sda_i};
            next_link.cnt       = gxp_pkg::GXP_SECOND_BIT; // see (R02)
        end
        else
        begin
            case (link.state)
                gxp_pkg::st_addr:
                begin
                    next_link.rx  = {link.rx[6:0], sda_i};
                    next_link.cnt = link.cnt + gxp_pkg::GXP_CNT_STEP;
                    if (link.cnt == gxp_pkg::GXP_LAST_BIT)
                    begin
                        next_link.rw = sda_i;
                        if (addr_hit)
                            next_link.state = gxp_pkg::st_addr_ack; // see (R01)
                        else
                            next_link.state = gxp_pkg::st_idle; // see (R12)
                    end
                end
                gxp_pkg::st_addr_ack:
                begin
                    next_link.cnt = gxp_pkg::GXP_FIRST_BIT;
                    if (link.rw)
                    begin
                        next_link.tx    = gpio_s; // see (R09) (R07)
                        next_link.state = gxp_pkg::st_rd_data;
                    end
                    else
                        next_link.state = gxp_pkg::st_wr_data; // see (R03)
                end
                gxp_pkg::st_wr_data:
                begin
                    next_link.rx  = {link.rx[6:0], sda_i};
                    next_link.cnt = link.cnt + gxp_pkg::GXP_CNT_STEP;
                    if (link.cnt == gxp_pkg::GXP_LAST_BIT)
                    begin
                        // whole byte only, published by a toggle
                        next_link.wr_data = {link.rx[6:0], sda_i}; // see (R08)
                        next_link.wr_tog  = ~link.wr_tog;
                        next_link.state   = gxp_pkg::st_wr_ack; // see (R04)
                    end
                end
                gxp_pkg::st_wr_ack:
                begin
                    next_link.cnt   = gxp_pkg::GXP_FIRST_BIT;
                    next_link.state = gxp_pkg::st_wr_data; // see (R05)
                end
                gxp_pkg::st_rd_data:
                begin
                    next_link.tx  = {link.tx[6:0], 1'b0};
                    next_link.cnt = link.cnt + gxp_pkg::GXP_CNT_STEP;
                    if (link.cnt == gxp_pkg::GXP_LAST_BIT)
                        next_link.state = gxp_pkg::st_rd_ack; // see (R04)
                end
                gxp_pkg::st_rd_ack:
                begin
                    next_link.cnt = gxp_pkg::GXP_FIRST_BIT;
                    if (!sda_i)
                    begin
                        // master acknowledged: sample again, send again
                        next_link.tx    = gpio_s; // see (R10)
                        next_link.state = gxp_pkg::st_rd_data;
                    end
                    else
                        next_link.state = gxp_pkg::st_idle;
                end
                default:
                    next_link.state = gxp_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge scl_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            link.state     <= gxp_pkg::st_idle;
            link.cnt       <= gxp_pkg::GXP_CNT_RST;
            link.rx        <= gxp_pkg::GXP_SHIFT_RST;
            link.tx        <= gxp_pkg::GXP_SHIFT_RST;
            link.rw        <= 1'b0;
            link.wr_data   <= gxp_pkg::GXP_GPIO_RST;
            link.wr_tog    <= 1'b0;
            link.start_ack <= 1'b0;
        end
        else
            link <= next_link;
    end

    // data line changes only while the bus clock is low
    always_comb
    begin
        next_sda_drive = 1'b0;
        case (link.state)
            gxp_pkg::st_addr_ack: next_sda_drive = 1'b1; // see (R03)
            gxp_pkg::st_wr_ack:   next_sda_drive = 1'b1; // see (R04)
            gxp_pkg::st_rd_data:  next_sda_drive = ~link.tx[7]; // see (R09)
            default:              next_sda_drive = 1'b0; // see (R12)
        endcase
    end

    always_ff @(negedge scl_i or negedge rst_b)
    begin
        if (!rst_b)
            sda_drive <= 1'b0;
        else
            sda_drive <= next_sda_drive;
    end

    assign sda_oe = sda_drive; // see (R11)

    // write toggle and frame markers cross into the system domain
    gxp_sync #(
        .WIDTH  (1),
        .STAGES (gxp_pkg::GXP_SYNC_STAGES)
    ) u_wr_sync (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .d     (link.wr_tog),
        .q     (wr_tog_s)
    );

    gxp_sync #(
        .WIDTH  (2),
        .STAGES (gxp_pkg::GXP_SYNC_STAGES)
    ) u_frame_sync (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .d     ({stop_tog, start_tog}),
        .q     (frame_s)
    );

    assign wr_pulse = (wr_tog_s != sys.wr_seen);

    always_comb
    begin
        next_sys            = sys;
        next_sys.wr_seen    = wr_tog_s;
        next_sys.frame_seen = frame_s;
        // wr_data stays still for a whole byte after its toggle moves
        if (wr_pulse)
            next_sys.gpio_out = link.wr_data; // see (R07) (R13)
        if (frame_s[1] != sys.frame_seen[1])
            next_sys.busy = 1'b0;
        if (frame_s[0] != sys.frame_seen[0])
            next_sys.busy = 1'b1; // see (R05)
        next_sys.scl_o  = 1'b0;
        next_sys.scl_oe = 1'b0;
        next_sys.sda_o  = 1'b0; // see (R11)
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sys.wr_seen    <= 1'b0;
            sys.frame_seen <= 2'h0;
            sys.busy       <= 1'b0;
            sys.gpio_out   <= gxp_pkg::GXP_GPIO_RST;
            sys.scl_o      <= 1'b0;
            sys.scl_oe     <= 1'b0;
            sys.sda_o      <= 1'b0;
        end
        else
            sys <= next_sys;
    end

    assign gpio_out  = sys.gpio_out; // see (R06)
    assign link_busy = sys.busy;
    assign scl_o     = sys.scl_o;
    assign scl_oe    = sys.scl_oe;
    assign sda_o     = sys.sda_o;

    // checks in the link domain
    sequence s_wr_byte;
        (link.state == gxp_pkg::st_wr_data && link.cnt == 3'h0
         && !start_seen) ##1 (!start_seen)[*7];
    endsequence

    sequence s_rd_go;
        link.state == gxp_pkg::st_rd_ack && !sda_i && !start_seen;
    endsequence

    property p_ack_match;
        @(posedge scl_i) disable iff (!rst_b)
        link.state == gxp_pkg::st_addr_ack |-> sda_drive;
    endproperty
    a_ack_match: assert property (p_ack_match) // see (R03)
        else $error("no acknowledge for own address");

    property p_miss;
        @(posedge scl_i) disable iff (!rst_b)
        (link.state == gxp_pkg::st_addr && link.cnt == 3'h7 && !start_seen
         && link.rx[6:0] != DEV_ADDR)
        |=> link.state == gxp_pkg::st_idle ##0 !sda_drive;
    endproperty
    a_miss: assert property (p_miss) // see (R12)
        else $error("foreign address not ignored");

    property p_wr_byte;
        @(posedge scl_i) disable iff (!rst_b)
        s_wr_byte |=> link.state == gxp_pkg::st_wr_ack && sda_drive
            && link.wr_data == link.rx;
    endproperty
    a_wr_byte: assert property (p_wr_byte) // see (R04)
        else $error("write byte not followed by acknowledge slot");

    property p_wr_ack_low;
        @(posedge scl_i) disable iff (!rst_b)
        link.state == gxp_pkg::st_wr_ack |-> sda_drive;
    endproperty
    a_wr_ack_low: assert property (p_wr_ack_low) // see (R08)
        else $error("received byte not acknowledged");

    property p_rd_sample;
        @(posedge scl_i) disable iff (!rst_b)
        (link.state == gxp_pkg::st_addr_ack && link.rw && !start_seen)
        |=> link.tx == $past(gpio_s) ##0 link.state == gxp_pkg::st_rd_data;
    endproperty
    a_rd_sample: assert property (p_rd_sample) // see (R09)
        else $error("inputs not sampled at acknowledge");

    property p_rd_repeat;
        @(posedge scl_i) disable iff (!rst_b)
        s_rd_go |=> link.state == gxp_pkg::st_rd_data && link.cnt == 3'h0;
    endproperty
    a_rd_repeat: assert property (p_rd_repeat) // see (R10)
        else $error("read did not continue after acknowledge");

    property p_start;
        @(posedge scl_i) disable iff (!rst_b)
        start_seen |=> link.state == gxp_pkg::st_addr && link.cnt == 3'h1;
    endproperty
    a_start: assert property (p_start) // see (R02)
        else $error("start did not restart address phase");

    // checks in the system domain
    property p_out_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        !wr_pulse |=> $stable(gpio_out);
    endproperty
    a_out_hold: assert property (p_out_hold) // see (R13)
        else $error("outputs changed without a completed byte");

    property p_out_load;
        @(posedge sys_clk) disable iff (!rst_b)
        wr_pulse |=> gpio_out == $past(link.wr_data);
    endproperty
    a_out_load: assert property (p_out_load) // see (R07)
        else $error("outputs not loaded from received byte");

    property p_no_high;
        @(posedge sys_clk) disable iff (!rst_b)
        !sda_o && !scl_o && !scl_oe;
    endproperty
    a_no_high: assert property (p_no_high) // see (R11)
        else $error("bus pin driven high");

endmodule // gxp_i2c_gpio

`default_nettype wire

// File: sim/gxp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module gxp_host_model (
    // wire levels
    input  wire logic scl_line,
    input  wire logic sda_line,
    // open-drain pulls, high pulls the line low
    output logic      scl_low,
    output logic      sda_low
);
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // data moves only while the clock is low, 6 ns per slot
    task automatic bit_slot(input logic b, output logic s);
        sda_low = ~b;
        #1.5 scl_low = 1'b0;
        #1.5 s = sda_line;
        #1.5 scl_low = 1'b1;
        #1.5;
    endtask

    // works from idle and as a repeated start with the clock held low
    task automatic start();
        sda_low = 1'b0;
        #1.5 scl_low = 1'b0;
        #1.5 sda_low = 1'b1;
        #1.5 scl_low = 1'b1;
        #1.5;
    endtask

    // clock and data are left released, so both stand high between frames
    task automatic stop();
        sda_low = 1'b1;
        #1.5 scl_low = 1'b0;
        #1.5 sda_low = 1'b0;
        #3;
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(b[i], s);
        end
        bit_slot(1'b1, s);
        ack = ~s;
    endtask

    task automatic rd_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(1'b1, s);
            b[i] = s;
        end
        bit_slot(~more, s);
    endtask
endmodule // gxp_host_model

`default_nettype wire

// File: sim/gxp_i2c_gpio_test.sv
`timescale 1ns/1ps
`default_nettype none

module gxp_i2c_gpio_test;
    localparam logic [6:0] ADDR = gxp_pkg::GXP_DEV_ADDR;

    logic       sys_clk;
    logic       rst_b;
    logic [7:0] gpio_in;
    logic [7:0] gpio_out;
    logic       scl_o;
    logic       scl_oe;
    logic       sda_o;
    logic       sda_oe;
    logic       link_busy;
    logic       scl_low;
    logic       sda_low;
    logic       scl_line;
    logic       sda_line;
    logic       bad_pin;
    int         n_mismatch;
    int         checks;

    // pulled-up wires
    assign scl_line = ~(scl_low | (scl_oe & ~scl_o));
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    gxp_i2c_gpio dut (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .scl_i     (scl_line),
        .scl_o     (scl_o),
        .scl_oe    (scl_oe),
        .sda_i     (sda_line),
        .sda_o     (sda_o),
        .sda_oe    (sda_oe),
        .gpio_in   (gpio_in),
        .gpio_out  (gpio_out),
        .link_busy (link_busy)
    );

    gxp_host_model host (
        .scl_line (scl_line),
        .sda_line (sda_line),
        .scl_low  (scl_low),
        .sda_low  (sda_low)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // any high drive on either pin is latched for a later check
    always @(posedge sys_clk)
        if (rst_b && (scl_oe !== 1'b0 || scl_o !== 1'b0 || sda_o !== 1'b0))
            bad_pin <= 1'b1;

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got,
                     exp);
        end
    endtask

    task automatic wait_sys(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic set_in(input logic [7:0] v);
        @(posedge sys_clk);
        gpio_in <= v;
        wait_sys(2);
    endtask

    task automatic t_reset();
        cmp(gpio_out, gxp_pkg::GXP_GPIO_RST, "reset outputs");
        cmp(8'(sda_oe), 8'h00, "reset data pull");
        cmp(8'(link_busy), 8'h00, "reset busy");
        $display("test reset done");
    endtask

    task automatic t_write();
        logic             ack;
        logic [3:0][7:0]  vals;
        vals = {8'h81, 8'h00, 8'hff, 8'h5a};
        host.start();
        host.wr_byte({ADDR, 1'b0}, ack);
        cmp(8'(ack), 8'h01, "address ack");
        wait_sys(4);
        cmp(8'(link_busy), 8'h01, "busy in frame");
        for (int i = 0; i < 4; i++)
        begin
            host.wr_byte(vals[i], ack);
            cmp(8'(ack), 8'h01, "data ack");
            wait_sys(6);
            cmp(gpio_out, vals[i], "written byte");
        end
        host.stop();
        wait_sys(6);
        cmp(8'(link_busy), 8'h00, "busy after stop");
        cmp(gpio_out, 8'h81, "outputs hold");
        $display("test write done");
    endtask

    task automatic t_foreign();
        logic       ack;
        logic [7:0] d;
        host.start();
        host.wr_byte({ADDR ^ 7'h01, 1'b0}, ack);
        cmp(8'(ack), 8'h00, "foreign write address");
        host.wr_byte(8'h3c, ack);
        cmp(8'(ack), 8'h00, "foreign data ignored");
        host.stop();
        host.start();
        host.wr_byte({ADDR ^ 7'h40, 1'b1}, ack);
        cmp(8'(ack), 8'h00, "foreign read address");
        host.rd_byte(1'b0, d);
        cmp(d, 8'hff, "foreign read released");
        host.stop();
        wait_sys(6);
        cmp(gpio_out, 8'h81, "outputs untouched");
        $display("test foreign done");
    endtask

    task automatic t_read();
        logic       ack;
        logic [7:0] d;
        set_in(8'ha5);
        host.start();
        host.wr_byte({ADDR, 1'b1}, ack);
        cmp(8'(ack), 8'h01, "read address ack");
        set_in(8'h3c);
        host.rd_byte(1'b1, d);
        cmp(d, 8'ha5, "byte sampled at address ack");
        host.rd_byte(1'b0, d);
        cmp(d, 8'h3c, "byte sampled at master ack");
        host.stop();
        $display("test read done");
    endtask

    task automatic t_restart();
        logic       ack;
        logic [7:0] d;
        set_in(8'h96);
        host.start();
        host.wr_byte({ADDR, 1'b0}, ack);
        host.wr_byte(8'hc3, ack);
        cmp(8'(ack), 8'h01, "write before restart");
        host.start();
        host.wr_byte({ADDR, 1'b1}, ack);
        cmp(8'(ack), 8'h01, "address after restart");
        host.rd_byte(1'b0, d);
        cmp(d, 8'h96, "read after restart");
        host.stop();
        wait_sys(6);
        cmp(gpio_out, 8'hc3, "write kept over restart");
        cmp(8'(bad_pin), 8'h00, "pins never driven high");
        $display("test restart done");
    endtask

    task automatic t_midreset();
        logic ack;
        @(posedge sys_clk);
        rst_b <= 1'b0;
        wait_sys(2);
        cmp(gpio_out, gxp_pkg::GXP_GPIO_RST, "outputs in reset");
        cmp(8'(sda_oe), 8'h00, "data pull in reset");
        cmp(8'(link_busy), 8'h00, "busy in reset");
        rst_b <= 1'b1;
        wait_sys(2);
        host.start();
        host.wr_byte({ADDR, 1'b0}, ack);
        cmp(8'(ack), 8'h01, "address after reset");
        host.wr_byte(8'h69, ack);
        cmp(8'(ack), 8'h01, "data after reset");
        host.stop();
        wait_sys(6);
        cmp(gpio_out, 8'h69, "outputs after reset");
        $display("test mid-run reset done");
    endtask

    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end

    initial
    begin
        rst_b = 1'b0;
        gpio_in = 8'h00;
        bad_pin = 1'b0;
        n_mismatch = 0;
        checks = 0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        wait_sys(2);
        t_reset();
        t_write();
        t_foreign();
        t_read();
        t_restart();
        t_midreset();
        results();
    end
endmodule // gxp_i2c_gpio_test

`default_nettype wire
